/* core/hbia_consts.vh */
// Register offsets, field positions and reset values of the host bridge.
`ifndef HBIA_CONSTS_VH
`define HBIA_CONSTS_VH
`define HBIA_OFS_IWDATA     7'h50
`define HBIA_OFS_IRDATA     7'h51
`define HBIA_OFS_IADDR_LO   7'h52
`define HBIA_OFS_IADDR_HI   7'h53
`define HBIA_OFS_AUTOINC    7'h54
`define HBIA_OFS_RDBK_LO    7'h56
`define HBIA_OFS_RDBK_HI    7'h57
`define HBIA_OFS_RSV_CTRL   7'h5A
`define HBIA_OFS_BUF_RDY    7'h5C
`define HBIA_OFS_CPU_RST    7'h5D
`define HBIA_OFS_DOORBELL   7'h60
`define HBIA_OFS_BUF_PORT   7'h70
`define HBIA_OFS_PAGE_SEL   7'h7F
`define HBIA_COMM_LAST      7'h4F
`define HBIA_BIT_AUTOINC    0
`define HBIA_BIT_SDRAM_RDY  0
`define HBIA_BIT_DISP_RDY   1
`define HBIA_BIT_CPU_RST    0
`define HBIA_BIT_SUSPEND    1
`define HBIA_BIT_DOORBELL   1
`define HBIA_BIT_PAGE_SEL   0
`define HBIA_RST_BYTE       8'h00
`define HBIA_RST_ADDR       16'h0000
`define HBIA_BLK_SHIFT      12
`define HBIA_BLK_COUNT      13
`endif

/* core/hbia_bridge.v */
// Host bridge with indirect register window, buffer FIFO and CPU reset.
// What this block does
// (RQ1) Host byte at write data port becomes internal write at current address.
// (RQ2) Offsets 0x50 to 0x54 serve only indirect internal register access.
// (RQ3) Host keeps on-chip CPU in reset before any indirect access.
// (RQ4) Read data port returns internal register byte at current address.
// (RQ5) Sixteen-bit internal address built from writable low and high bytes.
// (RQ6) High address nibble picks function block, each spanning 4 KB.
// (RQ7) Nibble 0 to C decodes global, CPU, colour, DMA, ... 2D graphics.
// (RQ8) With auto-increment set, data port accesses run on continuously.
// (RQ9) Auto-increment adds one per data port access; otherwise address holds.
// (RQ10) Host gets burst access to the internal buffers.
// (RQ11) Buffer words are 16 bits, sent low byte then high byte.
// (RQ12) Read-back ports return last word the host wrote to a buffer.
// (RQ13) High read-back port unused when the 8-bit host bus is selected.
// (RQ14) Status bit 0 is SDRAM buffer ready, bit 1 display ready.
// (RQ15) Host checks buffer ready bit before reading the buffer data port.
// (RQ16) Writing 1 to CPU reset bit 0 holds on-chip CPU in reset.
// (RQ17) CPU reset defaults to 0 for host boot, 1 for mask ROM boot.
// (RQ18) Host downloads code, then writes 0 to CPU reset to start CPU.
// (RQ19) Writing 1 to doorbell bit 1 interrupts the on-chip CPU.
// (RQ20) Byte written with address line low selects the 7-bit register.
// (RQ21) Offsets 0x00-0x4F reach the communication page, 0x50-0x7F control.
`timescale 1ns/1ps
`default_nettype none
`include "hbia_consts.vh"

// Word FIFO with valid and ready on both sides.
module hbia_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             rst_n_i,
  // Filling side.
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Draining side.
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage has no reset; only pointers and count need a defined value.
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which must be a power of two.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // hbia_fifo

// Top of the host bridge control logic.
module hbia_bridge #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  // Clock and reset.
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // Host parallel bus pins.
  input  wire        hb_cs_n_i,
  input  wire        hb_wr_n_i,
  input  wire        hb_rd_n_i,
  input  wire        hb_a0_i,
  input  wire [7:0]  hb_data_i,
  output reg  [7:0]  hb_data_o,
  output reg         hb_data_oe_o,
  output reg         hb_busy_o,
  // Straps, sampled once after reset release.
  input  wire        boot_from_rom_i,
  input  wire        bus16_mode_i,
  // Internal module register bus.
  output reg  [15:0] int_addr_o,
  output reg  [12:0] int_blk_sel_o,
  output reg  [7:0]  int_wdata_o,
  output reg         int_wr_o,
  output reg         int_rd_o,
  input  wire [7:0]  int_rdata_i,
  // Communication page access.
  output reg  [6:0]  comm_addr_o,
  output reg         page_select_o,
  output reg  [7:0]  comm_wdata_o,
  output reg         comm_wr_o,
  output reg         comm_rd_o,
  input  wire [7:0]  comm_rdata_i,
  // Buffer write word stream.
  output reg         buf_valid_o,
  output reg  [15:0] buf_data_o,
  input  wire        buf_ready_i,
  // Buffer readiness from the buffer controllers.
  input  wire        sdram_buffer_ready_i,
  input  wire        display_buffer_ready_i,
  // On-chip CPU control.
  output reg         cpu_soft_reset_o,
  output reg         cpu_doorbell_o,
  output reg  [7:0]  reserved_control_o
);
  // Pin synchronisers: stage one is read only by stage two.
  reg [3:0]  pin_s1_reg;
  reg [3:0]  pin_s2_reg;
  reg [3:0]  pin_s3_reg;
  reg [7:0]  dat_s1_reg;
  reg [7:0]  dat_s2_reg;
  // Register file.
  reg [6:0]  index_reg;
  reg [15:0] iaddr_reg;
  reg [15:0] iaddr_next;
  reg        autoinc_reg;
  reg [15:0] rdbk_reg;
  reg [7:0]  buf_lo_reg;
  reg        buf_half_reg;
  reg [1:0]  rdy_reg;
  reg        suspend_reg;
  reg        doorbell_reg;
  reg [7:0]  rd_data_reg;
  reg        rd_pend_reg;
  reg        comm_pend_reg;
  reg        strap_done_reg;
  reg        bus16_reg;
  reg [7:0]  read_mux;
  // FIFO wiring.
  reg        fifo_in_valid_reg;
  reg [15:0] fifo_in_data_reg;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire       wr_done;
  wire       rd_start;
  wire       rd_done;
  wire       a0_s;
  wire       cs_s;
  wire       out_take;
  integer    k;

  // Pin order in the sync vector: cs, wr, rd, a0.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 4'hE;
      pin_s2_reg <= 4'hE;
      pin_s3_reg <= 4'hE;
      dat_s1_reg <= `HBIA_RST_BYTE;
      dat_s2_reg <= `HBIA_RST_BYTE;
    end else begin
      pin_s1_reg <= {hb_cs_n_i, hb_wr_n_i, hb_rd_n_i, hb_a0_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      dat_s1_reg <= hb_data_i;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  // A strobe ends on its rising edge; chip select is checked at stage two.
  assign cs_s     = ~pin_s2_reg[3];
  assign a0_s     = pin_s3_reg[0];
  assign wr_done  = cs_s & pin_s2_reg[2] & ~pin_s3_reg[2];
  assign rd_start = cs_s & ~pin_s2_reg[1] & pin_s3_reg[1];
  assign rd_done  = pin_s2_reg[1] & ~pin_s3_reg[1];

  // Next address: one more after each data port access when enabled.
  // A write advances in the cycle after its pulse, so it lands at the old one.
  always @* begin
    iaddr_next = iaddr_reg;
    // (RQ9) advance after access
    if (autoinc_reg && (int_wr_o || (rd_done && rd_pend_reg))) begin
      // (RQ8) continuous port access
      iaddr_next = iaddr_reg + 16'h0001;
    end
  end

  // Read mux for the control section; unmapped offsets read as zero.
  always @* begin
    read_mux = `HBIA_RST_BYTE;
    if (index_reg <= `HBIA_COMM_LAST) begin
      read_mux = rd_data_reg;
    end else if (index_reg == `HBIA_OFS_IWDATA) begin
      read_mux = int_wdata_o;
    end else if (index_reg == `HBIA_OFS_IRDATA) begin
      // (RQ4) indirect read byte
      read_mux = rd_data_reg;
    end else if (index_reg == `HBIA_OFS_IADDR_LO) begin
      read_mux = iaddr_reg[7:0];
    end else if (index_reg == `HBIA_OFS_IADDR_HI) begin
      read_mux = iaddr_reg[15:8];
    end else if (index_reg == `HBIA_OFS_AUTOINC) begin
      read_mux = {7'h00, autoinc_reg};
    end else if (index_reg == `HBIA_OFS_RDBK_LO) begin
      // (RQ12) last written word
      read_mux = rdbk_reg[7:0];
    end else if (index_reg == `HBIA_OFS_RDBK_HI) begin
      // (RQ13) unused in 8-bit mode
      read_mux = bus16_reg ? rdbk_reg[15:8] : `HBIA_RST_BYTE;
    end else if (index_reg == `HBIA_OFS_RSV_CTRL) begin
      read_mux = reserved_control_o;
    end else if (index_reg == `HBIA_OFS_BUF_RDY) begin
      // (RQ14) buffer ready status
      read_mux = {6'h00, rdy_reg};
    end else if (index_reg == `HBIA_OFS_CPU_RST) begin
      read_mux = {6'h00, suspend_reg, cpu_soft_reset_o};
    end else if (index_reg == `HBIA_OFS_DOORBELL) begin
      read_mux = {6'h00, doorbell_reg, 1'b0};
    end else if (index_reg == `HBIA_OFS_PAGE_SEL) begin
      read_mux = {7'h00, page_select_o};
    end
  end

  // Host write decode, indirect access and CPU control.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_reg          <= 7'h00;
      iaddr_reg          <= `HBIA_RST_ADDR;
      autoinc_reg        <= 1'b0;
      int_addr_o         <= `HBIA_RST_ADDR;
      int_blk_sel_o      <= 13'h0001;
      int_wdata_o        <= `HBIA_RST_BYTE;
      int_wr_o           <= 1'b0;
      int_rd_o           <= 1'b0;
      comm_addr_o        <= 7'h00;
      page_select_o      <= 1'b0;
      comm_wdata_o       <= `HBIA_RST_BYTE;
      comm_wr_o          <= 1'b0;
      comm_rd_o          <= 1'b0;
      reserved_control_o <= `HBIA_RST_BYTE;
      suspend_reg        <= 1'b0;
      doorbell_reg       <= 1'b0;
      cpu_doorbell_o     <= 1'b0;
      cpu_soft_reset_o   <= 1'b0;
      strap_done_reg     <= 1'b0;
      bus16_reg          <= 1'b0;
      rd_pend_reg        <= 1'b0;
      comm_pend_reg      <= 1'b0;
      rd_data_reg        <= `HBIA_RST_BYTE;
      rdy_reg            <= 2'b00;
    end else begin
      int_wr_o       <= 1'b0;
      int_rd_o       <= 1'b0;
      comm_wr_o      <= 1'b0;
      comm_rd_o      <= 1'b0;
      cpu_doorbell_o <= 1'b0;
      rdy_reg <= {display_buffer_ready_i, sdram_buffer_ready_i};
      // (RQ17) boot strap default
      if (!strap_done_reg) begin
        strap_done_reg   <= 1'b1;
        cpu_soft_reset_o <= boot_from_rom_i;
        bus16_reg        <= bus16_mode_i;
      end
      // (RQ5) sixteen-bit address
      iaddr_reg  <= iaddr_next;
      int_addr_o <= iaddr_next;
      // (RQ6) 4 KB block select
      for (k = 0; k < `HBIA_BLK_COUNT; k = k + 1) begin
        // (RQ7) nibble decode order
        int_blk_sel_o[k] <= (iaddr_next[15:`HBIA_BLK_SHIFT] == k[3:0]);
      end
      if (wr_done && !a0_s) begin
        // (RQ20) address byte
        index_reg <= dat_s2_reg[6:0];
      end else if (wr_done) begin
        if (index_reg <= `HBIA_COMM_LAST) begin
          // (RQ21) communication page
          comm_addr_o  <= index_reg;
          comm_wdata_o <= dat_s2_reg;
          comm_wr_o    <= 1'b1;
        end else if (index_reg == `HBIA_OFS_IWDATA) begin
          // (RQ1) forward write
          int_wdata_o <= dat_s2_reg;
          int_wr_o    <= 1'b1;
        end else if (index_reg == `HBIA_OFS_IADDR_LO) begin
          iaddr_reg[7:0]  <= dat_s2_reg;
          int_addr_o[7:0] <= dat_s2_reg;
        end else if (index_reg == `HBIA_OFS_IADDR_HI) begin
          iaddr_reg[15:8]  <= dat_s2_reg;
          int_addr_o[15:8] <= dat_s2_reg;
          for (k = 0; k < `HBIA_BLK_COUNT; k = k + 1) begin
            int_blk_sel_o[k] <= (dat_s2_reg[7:4] == k[3:0]);
          end
        end else if (index_reg == `HBIA_OFS_AUTOINC) begin
          // (RQ2) indirect window control
          autoinc_reg <= dat_s2_reg[`HBIA_BIT_AUTOINC];
        end else if (index_reg == `HBIA_OFS_RSV_CTRL) begin
          reserved_control_o <= dat_s2_reg;
        end else if (index_reg == `HBIA_OFS_CPU_RST) begin
          // (RQ16) CPU soft reset
          cpu_soft_reset_o <= dat_s2_reg[`HBIA_BIT_CPU_RST];
          suspend_reg      <= dat_s2_reg[`HBIA_BIT_SUSPEND];
        end else if (index_reg == `HBIA_OFS_DOORBELL) begin
          // (RQ19) doorbell interrupt
          doorbell_reg   <= dat_s2_reg[`HBIA_BIT_DOORBELL];
          cpu_doorbell_o <= dat_s2_reg[`HBIA_BIT_DOORBELL];
        end else if (index_reg == `HBIA_OFS_PAGE_SEL) begin
          page_select_o <= dat_s2_reg[`HBIA_BIT_PAGE_SEL];
        end
      end
      // Fetch at the start of a read; the sync delay covers the latency.
      if (rd_start && index_reg == `HBIA_OFS_IRDATA) begin
        int_rd_o    <= 1'b1;
        rd_pend_reg <= 1'b1;
      end else if (rd_start && index_reg <= `HBIA_COMM_LAST) begin
        comm_addr_o   <= index_reg;
        comm_rd_o     <= 1'b1;
        comm_pend_reg <= 1'b1;
      end else if (rd_done) begin
        rd_pend_reg   <= 1'b0;
        comm_pend_reg <= 1'b0;
      end
      if (int_rd_o) begin
        rd_data_reg <= int_rdata_i;
      end else if (comm_rd_o) begin
        rd_data_reg <= comm_rdata_i;
      end
    end
  end

  // Buffer words are paired low byte first, then pushed into the FIFO.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_lo_reg        <= `HBIA_RST_BYTE;
      buf_half_reg      <= 1'b0;
      rdbk_reg          <= 16'h0000;
      fifo_in_valid_reg <= 1'b0;
      fifo_in_data_reg  <= 16'h0000;
    end else begin
      if (fifo_in_valid_reg && fifo_in_ready) begin
        fifo_in_valid_reg <= 1'b0;
      end
      if (wr_done && a0_s && index_reg == `HBIA_OFS_BUF_PORT) begin
        if (!buf_half_reg) begin
          // (RQ11) low byte first
          buf_lo_reg   <= dat_s2_reg;
          buf_half_reg <= 1'b1;
        end else begin
          // (RQ10) burst buffer word
          buf_half_reg      <= 1'b0;
          fifo_in_valid_reg <= 1'b1;
          fifo_in_data_reg  <= {dat_s2_reg, buf_lo_reg};
          rdbk_reg          <= {dat_s2_reg, buf_lo_reg};
        end
      end
    end
  end

  // Buffer word queue; a stalled drain raises the busy pin to the host.
  hbia_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (out_take),
    .out_data_o  (fifo_out_data)
  );

  // Output stage: the stream register takes a word when it is free.
  assign out_take = ~buf_valid_o | buf_ready_i;

  // Host read data and stream outputs, all from flip-flops.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hb_data_o    <= `HBIA_RST_BYTE;
      hb_data_oe_o <= 1'b0;
      hb_busy_o    <= 1'b0;
      buf_valid_o  <= 1'b0;
      buf_data_o   <= 16'h0000;
    end else begin
      hb_data_o    <= read_mux;
      hb_data_oe_o <= cs_s & ~pin_s2_reg[1] & pin_s3_reg[0];
      hb_busy_o    <= ~fifo_in_ready | fifo_in_valid_reg;
      if (out_take) begin
        buf_valid_o <= fifo_out_valid;
        buf_data_o  <= fifo_out_data;
      end
    end
  end
endmodule // hbia_bridge
`default_nettype wire

/* test/hbia_props_properties.sv */
// Concurrent checks on the host bridge top ports.
`timescale 1ns/1ps
`default_nettype none
module hbia_props (
  // Clock, reset and strap.
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        boot_from_rom_i,
  // Host pins.
  input wire logic        hb_wr_n_i,
  input wire logic        hb_rd_n_i,
  input wire logic        hb_data_oe_o,
  // Internal side.
  input wire logic [15:0] int_addr_o,
  input wire logic [12:0] int_blk_sel_o,
  input wire logic        int_wr_o,
  input wire logic        int_rd_o,
  input wire logic        buf_valid_o,
  input wire logic        buf_ready_i,
  input wire logic [15:0] buf_data_o,
  input wire logic        cpu_soft_reset_o,
  input wire logic        cpu_doorbell_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Timing relations between straps, host strobes, internal effects and the buffer stream.
  a_strap_reset: assert property (
    $rose(rst_n_i) |=> cpu_soft_reset_o == boot_from_rom_i)
    else $error("soft reset does not follow boot strap");
  a_block_decode: assert property (
    $stable(int_addr_o)[*2] ##0 int_addr_o[15:12] <= 4'hC
    |-> int_blk_sel_o == 13'h1 << int_addr_o[15:12])
    else $error("block select does not match address nibble");
  a_wr_single: assert property (
    int_wr_o |=> !int_wr_o) else $error("internal write longer than one");
  a_wr_addr_hold: assert property (
    int_wr_o |-> $stable(int_addr_o))
    else $error("internal address moved during write");
  a_rd_single: assert property (
    int_rd_o |=> !int_rd_o) else $error("internal read longer than one");
  a_bell_single: assert property (
    cpu_doorbell_o |=> !cpu_doorbell_o) else $error("doorbell too long");
  a_wr_cause: assert property (
    $rose(int_wr_o) |-> !($past(hb_wr_n_i,3) && $past(hb_wr_n_i,4)
    && $past(hb_wr_n_i,5) && $past(hb_wr_n_i,6)))
    else $error("internal write without host strobe");
  a_oe_idle: assert property (
    hb_rd_n_i[*8] |-> !hb_data_oe_o) else $error("bus driven while idle");
  a_oe_cause: assert property (
    $rose(hb_data_oe_o) |-> !$past(hb_rd_n_i,2))
    else $error("bus driven without read strobe");
  a_buf_hold: assert property (
    buf_valid_o && !buf_ready_i |=> buf_valid_o && $stable(buf_data_o))
    else $error("buffer word dropped while stalled");
endmodule // hbia_props
`default_nettype wire

/* test/hbia_host.sv */
// Host processor model driving the parallel bus pins.
`timescale 1ns/1ps
`default_nettype none
module hbia_host (
  // Clock and read data.
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  // Strobes, address line and write data.
  output var  logic       cs_n_o,
  output var  logic       wr_n_o,
  output var  logic       rd_n_o,
  output var  logic       a0_o,
  output var  logic [7:0] data_o
);
  // Idle bus at time zero.
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    a0_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Write strobes stay five cycles, read strobes nine, so the two-stage sync always sees them.
  task automatic put(input logic a, input logic [7:0] d);
    cyc(1);
    cs_n_o = 1'b0;
    a0_o = a;
    data_o = d;
    wr_n_o = 1'b0;
    cyc(5);
    wr_n_o = 1'b1;
    cyc(5);
    cs_n_o = 1'b1;
    data_o = ~d; // Released bus shows a changed value, never stale data.
    cyc(1);
  endtask
  task automatic rd8(output logic [7:0] d);
    cyc(1);
    cs_n_o = 1'b0;
    a0_o = 1'b1;
    rd_n_o = 1'b0;
    cyc(9);
    d = data_i;
    rd_n_o = 1'b1;
    cyc(6);
    cs_n_o = 1'b1;
    cyc(1);
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    put(1'b0, {1'b0, a});
    put(1'b1, d);
  endtask
  task automatic rreg(input logic [6:0] a, output logic [7:0] d);
    put(1'b0, {1'b0, a});
    rd8(d);
  endtask
endmodule // hbia_host
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the host bridge control logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        rom = 1'b0;
  logic        wide = 1'b0;
  logic [15:0] clast = 16'h0000;
  logic        sdram_rdy = 1'b0;
  logic        disp_rdy = 1'b0;
  logic        buf_rdy = 1'b0;
  logic [7:0]  imem [0:255];
  int          n_errors = 0;
  int          checked = 0;
  int          n_bell = 0;
  int          n_rx = 0;
  wire  [7:0]  hb_do, hdat, iwd, rsvd, cwd;
  wire  [6:0]  caddr;
  wire         cwr, crd, psel;
  wire  [15:0] iaddr, bdata;
  wire  [12:0] blk;
  wire         cs_n, wr_n, rd_n, a0, oe, busy, iwr, ird, bvalid;
  wire         cpu_rst, bell;
  // Both register sides answer within the cycle of the read pulse.
  wire  [7:0]  rdata = ird ? imem[iaddr[7:0]] : 8'h00;
  wire  [7:0]  crdata = crd ? {1'b1, caddr} : 8'h00;
  // Clock at 25 MHz.
  always #20 ref_clk_i = ~ref_clk_i;
  hbia_host h (.clk_i(ref_clk_i), .data_i(hb_do), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .a0_o(a0), .data_o(hdat));
  hbia_bridge uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .hb_cs_n_i(cs_n), .hb_wr_n_i(wr_n), .hb_rd_n_i(rd_n), .hb_a0_i(a0),
    .hb_data_i(hdat), .hb_data_o(hb_do), .hb_data_oe_o(oe),
    .hb_busy_o(busy), .boot_from_rom_i(rom), .bus16_mode_i(wide),
    .int_addr_o(iaddr), .int_blk_sel_o(blk), .int_wdata_o(iwd),
    .int_wr_o(iwr), .int_rd_o(ird), .int_rdata_i(rdata),
    .comm_addr_o(caddr), .page_select_o(psel), .comm_wdata_o(cwd),
    .comm_wr_o(cwr), .comm_rd_o(crd), .comm_rdata_i(crdata),
    .buf_valid_o(bvalid),
    .buf_data_o(bdata), .buf_ready_i(buf_rdy),
    .sdram_buffer_ready_i(sdram_rdy), .display_buffer_ready_i(disp_rdy),
    .cpu_soft_reset_o(cpu_rst), .cpu_doorbell_o(bell),
    .reserved_control_o(rsvd));
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Far side: register stores take writes, the stream checks each word.
  always @(posedge ref_clk_i) begin
    if (iwr) imem[iaddr[7:0]] <= iwd;
    if (cwr) clast <= {psel, caddr, cwd};
    if (bell) n_bell <= n_bell + 1;
    if (bvalid && buf_rdy) begin
      chk("buf_word", bdata, 16'hA53C + n_rx);
      n_rx <= n_rx + 1;
    end
  end
  task automatic do_reset(input logic r, input logic w);
    rom = r;
    wide = w;
    rst_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic t_boot();
    logic [7:0] d;
    for (int r = 0; r < 2; r++) begin
      do_reset(r[0], 1'b0);
      chk("cpu_reset_pin", cpu_rst, r[0]);
      h.rreg(7'h5D, d);
      chk("cpu_reset_reg", d[0], r[0]);
    end
    $display("done boot");
  endtask
  task automatic t_ctrl();
    logic [7:0] d;
    h.wreg(7'h5D, 8'h00);
    chk("cpu_run", cpu_rst, 1'b0);
    h.wreg(7'h5D, 8'h01);
    chk("cpu_hold", cpu_rst, 1'b1);
    h.wreg(7'h60, 8'h02);
    h.rreg(7'h60, d);
    chk("bell_reg", d, 8'h02);
    chk("bell_count", n_bell, 1);
    h.wreg(7'h5A, 8'hC3);
    chk("rsv_pin", rsvd, 8'hC3);
    h.rreg(7'h55, d);
    chk("unmapped", d, 8'h00);
    $display("done control");
  endtask
  task automatic t_indirect();
    logic [7:0] d;
    h.wreg(7'h52, 8'h34);
    h.wreg(7'h53, 8'hA0);
    chk("addr", iaddr, 16'hA034);
    h.wreg(7'h54, 8'h01);
    h.wreg(7'h50, 8'h11);
    h.put(1'b1, 8'h22);
    h.put(1'b1, 8'h33);
    chk("addr_inc", iaddr, 16'hA037);
    for (int k = 0; k < 3; k++)
      chk("imem", imem[8'h34 + k], 17 * (k + 1));
    h.wreg(7'h52, 8'h34);
    h.rreg(7'h51, d);
    chk("rd_first", d, 8'h11);
    h.rd8(d);
    chk("rd_next", d, 8'h22);
    chk("addr_rd", iaddr, 16'hA036);
    h.wreg(7'h54, 8'h00);
    h.wreg(7'h50, 8'h5A);
    h.put(1'b1, 8'h66);
    chk("addr_hold", iaddr, 16'hA036);
    chk("imem_hold", imem[8'h36], 8'h66);
    $display("done indirect");
  endtask
  task automatic t_blocks();
    for (int n = 0; n < 13; n++) begin
      h.wreg(7'h53, {n[3:0], 4'h0});
      chk("blk_sel", blk, 13'h1 << n);
    end
    $display("done blocks");
  endtask
  task automatic t_status();
    logic [7:0] d;
    sdram_rdy = 1'b1;
    h.rreg(7'h5C, d);
    chk("rdy_sdram", d, 8'h01);
    sdram_rdy = 1'b0;
    disp_rdy = 1'b1;
    h.rreg(7'h5C, d);
    chk("rdy_disp", d, 8'h02);
    $display("done status");
  endtask
  task automatic t_comm();
    logic [7:0] d;
    h.wreg(7'h7F, 8'h01);
    chk("page_pin", psel, 1'b1);
    h.wreg(7'h12, 8'h5A);
    chk("comm_wr", clast, {1'b1, 7'h12, 8'h5A});
    h.rreg(7'h12, d);
    chk("comm_rd", d, 8'h92);
    $display("done comm");
  endtask
  // Far side stalls while filling, then drains at half rate.
  task automatic t_buffer();
    logic [7:0] d;
    int pushed;
    h.wreg(7'h70, 8'h3C);
    h.put(1'b1, 8'hA5);
    pushed = 1;
    h.rreg(7'h56, d);
    chk("rdbk_lo", d, 8'h3C);
    h.rreg(7'h57, d);
    chk("rdbk_hi", d, 8'h00);
    chk("stall_word", bdata, 16'hA53C);
    h.put(1'b0, 8'h70);
    while (busy === 1'b0 && pushed < 40) begin
      h.put(1'b1, 8'h3C + pushed[7:0]);
      h.put(1'b1, 8'hA5);
      pushed++;
    end
    chk("fifo_full", pushed >= 32 && busy === 1'b1, 1'b1);
    for (int w = 0; w < 400 && n_rx < pushed; w++) begin
      buf_rdy = w[0];
      @(posedge ref_clk_i);
      #1;
    end
    buf_rdy = 1'b0;
    chk("drained", n_rx, pushed);
    if (n_rx != pushed) results();
    // high half answers on a 16-bit host
    do_reset(1'b1, 1'b1);
    h.wreg(7'h70, 8'h3C);
    h.put(1'b1, 8'hA5);
    h.rreg(7'h57, d);
    chk("rdbk_hi_wide", d, 8'hA5);
    $display("done buffer");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    t_boot();
    t_ctrl();
    t_indirect();
    t_blocks();
    t_status();
    t_comm();
    t_buffer();
    results();
  end
endmodule // testbench
bind hbia_bridge hbia_props u_props (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .boot_from_rom_i(boot_from_rom_i),
  .hb_wr_n_i(hb_wr_n_i), .hb_rd_n_i(hb_rd_n_i),
  .hb_data_oe_o(hb_data_oe_o), .int_addr_o(int_addr_o),
  .int_blk_sel_o(int_blk_sel_o), .int_wr_o(int_wr_o),
  .int_rd_o(int_rd_o), .buf_valid_o(buf_valid_o),
  .buf_ready_i(buf_ready_i), .buf_data_o(buf_data_o),
  .cpu_soft_reset_o(cpu_soft_reset_o), .cpu_doorbell_o(cpu_doorbell_o));
`default_nettype wire
